// *** capcom_defs.svh ***
// Purpose: Constants of the dual-timer capture/compare array.
// Assumes: APB with 32-bit data and byte addresses on 8 address bits.
// Notes:   Definitions only; the package holds the types.
//
// Overview of operation
// - Two independent 16-bit timers with reload registers
// - Timer clock: prescaled system clock or peer overflow
// - Timer A may also count external events
// - Sixteen channels, each with timer and function chosen
// - Each channel owns one pin, input or output
// - One-cycle resolution; eight cycles when staggered
// - Mode 0: interrupt on every match, pin idle
// - Mode 1: pin toggles on every match
// - Mode 2: one interrupt per timer period
// - Mode 3: pin high on match, low on overflow
// - Double mode: two registers toggle one pin
// - Single-event option stops compare action after one event
// - Capture copies assigned timer into channel register
// - Every capture raises that channel's interrupt
// - Capture edge: rising, falling, or both
// - Compare runs continuously, acts on equality
`ifndef CAPCOM_DEFS_SVH
`define CAPCOM_DEFS_SVH

`define CH_N        16
`define TMR_MAX     16'hFFFF
`define STAG_LAST   3'h7

// ------------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------------
`define OFS_CTRL    8'h00
`define OFS_RELA    8'h04
`define OFS_RELB    8'h08
`define OFS_TMRA    8'h0C
`define OFS_TMRB    8'h10
`define OFS_STS     8'h14
`define OFS_MSK     8'h18
`define OFS_DBL     8'h1C
`define AREA_CFG    2'h1
`define AREA_VAL    2'h2

// ------------------------------------------------------------------
// Control fields and codes
// ------------------------------------------------------------------
`define CTRL_RUNA   0
`define CTRL_RUNB   1
`define CTRL_STAG   2
`define CTRL_SELA   6:4
`define CTRL_SELB   10:8
`define CLK_PEER    3'h5
`define CLK_EXT     3'h6

// Channel configuration: mode[2:0], edge[4:3], timer[5], single[6]
`define CFG_MODE    2:0
`define CFG_RISE    3
`define CFG_FALL    4
`define CFG_TSEL    5
`define CFG_ONCE    6
`define MODE_OFF    3'h0
`define MODE_CAP    3'h1
`define MODE_C0     3'h4
`define MODE_C1     3'h5
`define MODE_C2     3'h6
`define MODE_C3     3'h7

`endif

// *** capcom_pkg.sv ***
// Purpose: Types of the dual-timer capture/compare array.
// Assumes: capcom_defs.svh supplies the sizes.
// Notes:   The whole block state is one packed struct.
`include "capcom_defs.svh"
package capcom_pkg;
    typedef struct packed {
        logic [1:0][15:0]          tmr;
        logic [1:0][15:0]          rel;
        logic [10:0]               ctrl;
        logic [`CH_N-1:0]          sts;
        logic [`CH_N-1:0]          msk;
        logic [`CH_N/2-1:0]        dbl;
        logic [`CH_N-1:0][6:0]     cfg;
        logic [`CH_N-1:0][15:0]    val;
        logic [`CH_N-1:0]          pin;
        logic [`CH_N-1:0]          fired;
        logic [`CH_N-1:0]          done;
        logic [`CH_N-1:0]          s1;
        logic [`CH_N-1:0]          s2;
        logic [`CH_N-1:0]          prev;
        logic [2:0]                ext;
        logic [3:0]                presc;
        logic [2:0]                stag;
        logic [31:0]               prdata;
        logic                      slverr;
    } state_t;
endpackage

// *** capture_compare_unit.sv ***
// Purpose: Sixteen-channel capture/compare array on two reloadable timers.
// Assumes: Single 200 MHz clock; pins and external count are asynchronous.
// Notes:   Registers over APB, answer after one access cycle.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "capcom_defs.svh"

module capture_compare_unit (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [`CH_N-1:0]  pin_i,
    output logic      [`CH_N-1:0]  pin_o,
    output logic      [`CH_N-1:0]  pin_oe,
    input  wire logic              ext_count_i,
    input  wire logic              peer_ovf_i,
    output logic                   irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_cmp(input logic [2:0] m);
        is_cmp = m[2];
    endfunction

    function automatic logic drives_pin(input logic [2:0] m);
        drives_pin = (m == `MODE_C1) || (m == `MODE_C3);
    endfunction

    function automatic logic presc_tick(input logic [2:0] sel, input logic [3:0] p);
        case (sel)
            3'h0:    presc_tick = 1'b1;
            3'h1:    presc_tick = &p[0:0];
            3'h2:    presc_tick = &p[1:0];
            3'h3:    presc_tick = &p[2:0];
            3'h4:    presc_tick = &p[3:0];
            default: presc_tick = 1'b0;
        endcase
    endfunction

    // Returns {unmapped, data}
    function automatic logic [32:0] rd_mux(input capcom_pkg::state_t s, input logic [7:0] a);
        logic [32:0] d;
        d = {1'b0, 32'h0000_0000};
        case (a[7:6])
            `AREA_CFG: d[6:0] = s.cfg[a[5:2]];
            `AREA_VAL: d[15:0] = s.val[a[5:2]];
            2'h0: begin
                case (a)
                    `OFS_CTRL: d[10:0] = s.ctrl;
                    `OFS_RELA: d[15:0] = s.rel[0];
                    `OFS_RELB: d[15:0] = s.rel[1];
                    `OFS_TMRA: d[15:0] = s.tmr[0];
                    `OFS_TMRB: d[15:0] = s.tmr[1];
                    `OFS_STS:  d[15:0] = s.sts;
                    `OFS_MSK:  d[15:0] = s.msk;
                    `OFS_DBL:  d[7:0]  = s.dbl;
                    default:   d[32]   = 1'b1;
                endcase
            end
            default: d[32] = 1'b1;
        endcase
        rd_mux = d;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    capcom_pkg::state_t r;
    capcom_pkg::state_t n;

    logic              step;
    logic [1:0]        tick;
    logic [1:0]        ovf;
    logic [`CH_N-1:0]  evt;
    logic              t;
    logic [2:0]        m;
    logic              edge_hit;
    logic              match;
    logic              act;
    logic              wr;
    logic [3:0]        ch;
    logic [32:0]       rd;
    logic [`CH_N-1:0]  w1c;

    always_comb begin
        n        = r;
        evt      = '0;
        t        = 1'b0;
        m        = `MODE_OFF;
        edge_hit = 1'b0;
        match    = 1'b0;
        act      = 1'b0;
        w1c      = '0;
        ch       = paddr[5:2];
        wr       = psel && penable && pwrite;
        rd       = rd_mux(r, paddr);

        // --------------------------------------------------------------
        // Synchronisers and time base
        // --------------------------------------------------------------
        n.s1     = pin_i;
        n.s2     = r.s1;
        n.prev   = r.s2;
        n.ext    = {r.ext[1], r.ext[0], ext_count_i};
        n.presc  = r.presc + 4'h1;
        n.stag   = r.stag + 3'h1;
        // Staggered mode only lets the array act every eighth cycle;
        // peer or external events between steps are not counted.
        step = !r.ctrl[`CTRL_STAG] || (r.stag == `STAG_LAST);

        tick[0] = r.ctrl[`CTRL_RUNA] && step &&
                  (presc_tick(r.ctrl[`CTRL_SELA], r.presc) ||
                   (r.ctrl[`CTRL_SELA] == `CLK_PEER && peer_ovf_i) ||
                   (r.ctrl[`CTRL_SELA] == `CLK_EXT && r.ext[1] && !r.ext[2]));
        tick[1] = r.ctrl[`CTRL_RUNB] && step &&
                  (presc_tick(r.ctrl[`CTRL_SELB], r.presc) ||
                   (r.ctrl[`CTRL_SELB] == `CLK_PEER && peer_ovf_i));

        // --------------------------------------------------------------
        // Timers
        // --------------------------------------------------------------
        for (int k = 0; k < 2; k++) begin
            ovf[k] = tick[k] && (r.tmr[k] == `TMR_MAX);
            if (ovf[k]) begin
                n.tmr[k] = r.rel[k];
            end else if (tick[k]) begin
                n.tmr[k] = r.tmr[k] + 16'h0001;
            end
        end

        // --------------------------------------------------------------
        // Channels
        // --------------------------------------------------------------
        for (int i = 0; i < `CH_N; i++) begin
            t = r.cfg[i][`CFG_TSEL];
            m = r.cfg[i][`CFG_MODE];
            edge_hit = (r.cfg[i][`CFG_RISE] && r.s2[i] && !r.prev[i]) ||
                       (r.cfg[i][`CFG_FALL] && !r.s2[i] && r.prev[i]);
            match = tick[t] && (n.tmr[t] == r.val[i]) && !r.done[i];
            act = 1'b0;
            if (m == `MODE_CAP) begin
                if (step && edge_hit) begin
                    n.val[i] = r.tmr[t];
                    evt[i]   = 1'b1;
                end
            end else if (is_cmp(m)) begin
                if (ovf[t]) begin
                    n.fired[i] = 1'b0;
                    if (m == `MODE_C3) begin
                        n.pin[i] = 1'b0;
                    end
                end
                if (match) begin
                    case (m)
                        `MODE_C0: act = 1'b1;
                        `MODE_C1: act = 1'b1;
                        `MODE_C2: act = !r.fired[i];
                        `MODE_C3: act = !r.fired[i];
                        default:  act = 1'b0;
                    endcase
                end
                if (act) begin
                    evt[i] = 1'b1;
                    if (m == `MODE_C2 || m == `MODE_C3) begin
                        n.fired[i] = 1'b1;
                    end
                    if (m == `MODE_C3) begin
                        n.pin[i] = 1'b1;
                    end
                    if (r.cfg[i][`CFG_ONCE]) begin
                        n.done[i] = 1'b1;
                    end
                    if (m == `MODE_C1) begin
                        // Odd channel of an active pair toggles the even pin
                        if ((i % 2 == 1) && r.dbl[i/2]) begin
                            n.pin[i-1] = n.pin[i-1] ^ 1'b1;
                        end else begin
                            n.pin[i] = n.pin[i] ^ 1'b1;
                        end
                    end
                end
            end
        end

        // --------------------------------------------------------------
        // APB slave
        // --------------------------------------------------------------
        if (psel && !penable) begin
            n.prdata = pwrite ? 32'h0000_0000 : rd[31:0];
            n.slverr = rd[32];
        end
        if (wr && !rd[32]) begin
            case (paddr[7:6])
                `AREA_CFG: begin
                    n.cfg[ch]   = pwdata[6:0];
                    // Rewriting the setup re-arms single-event and period lock
                    n.done[ch]  = 1'b0;
                    n.fired[ch] = 1'b0;
                end
                `AREA_VAL: n.val[ch] = pwdata[15:0];
                default: begin
                    case (paddr)
                        `OFS_CTRL: n.ctrl   = pwdata[10:0];
                        `OFS_RELA: n.rel[0] = pwdata[15:0];
                        `OFS_RELB: n.rel[1] = pwdata[15:0];
                        `OFS_TMRA: n.tmr[0] = pwdata[15:0];
                        `OFS_TMRB: n.tmr[1] = pwdata[15:0];
                        `OFS_STS:  w1c      = pwdata[15:0];
                        `OFS_MSK:  n.msk    = pwdata[15:0];
                        `OFS_DBL:  n.dbl    = pwdata[7:0];
                        default:   n.msk    = r.msk;
                    endcase
                end
            endcase
        end
        // A new event wins over a write-one clear in the same cycle
        n.sts = (r.sts & ~w1c) | evt;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < `CH_N; i++) begin
            pin_oe[i] = drives_pin(r.cfg[i][`CFG_MODE]) &&
                        !((i % 2 == 1) && r.dbl[i/2]);
        end
    end

    assign pin_o   = r.pin;
    assign prdata  = r.prdata;
    assign pslverr = r.slverr;
    assign pready  = psel && penable;
    assign irq     = |(r.sts & r.msk);

endmodule // capture_compare_unit

// *** capcom_chk.sv ***
// Purpose: Port-level checks of the capture/compare array.
// Assumes: Zero-wait APB slave, one clock domain.
// Notes:   Bound to the unit from the bench top.
`timescale 1ns/1ps
`include "capcom_defs.svh"
module capcom_chk (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [`CH_N-1:0] pin_i,
    input wire logic [`CH_N-1:0] pin_o,
    input wire logic [`CH_N-1:0] pin_oe,
    input wire logic             ext_count_i,
    input wire logic             peer_ovf_i,
    input wire logic             irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wacc = psel && penable && pwrite;
    wire setup = psel && !penable;
    chk_ready_access: assert property (acc |-> pready) else $error("pready low in access");
    chk_ready_idle: assert property (!acc |-> !pready) else $error("pready high outside access");
    chk_data_stands: assert property (acc |=> $stable(prdata) && $stable(pslverr)) else $error("read answer moved");
    chk_err_unmapped: assert property (setup && paddr == 8'hC0 |=> pslverr) else $error("no error on hole");
    chk_err_mapped: assert property (setup && paddr == `OFS_CTRL |=> !pslverr) else $error("error on control");
    chk_err_setup: assert property ($changed(pslverr) |-> $past(setup)) else $error("error moved off setup");
    // Pins turn to outputs only through configuration writes
    chk_oe_by_write: assert property ($changed(pin_oe) |-> $past(wacc) || $past(wacc, 2)) else $error("oe moved");
    // Sticky status: only a write can drop the request
    chk_irq_sticky: assert property ($fell(irq) |-> $past(wacc) || $past(wacc, 2)) else $error("irq fell");
    chk_reset_quiet: assert property ($rose(presetn) |-> !irq && pin_oe == 16'h0000) else $error("not idle");
    cover property ($rose(irq));
    cover property ($rose(pin_o[6]));
    cover property (setup && paddr == 8'hC0);
endmodule // capcom_chk

// *** pin_partner.sv ***
// Purpose: Far-side model of the channel pins.
// Assumes: The bench sets the external level of each pin.
// Notes:   A pin the unit drives reads back the unit's level.
`timescale 1ns/1ps
`include "capcom_defs.svh"
module pin_partner (
    input  wire logic [`CH_N-1:0] ext_lvl,
    input  wire logic [`CH_N-1:0] pin_o,
    input  wire logic [`CH_N-1:0] pin_oe,
    output logic      [`CH_N-1:0] pin_i
);
    // External source sits behind a resistor, so the unit's driver wins
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule // pin_partner

// *** test_capture_compare_unit.sv ***
// Purpose: Self-checking bench of the capture/compare array.
// Assumes: APB answers without wait states; pins via pin_partner.
// Notes:   Timer A runs with a 64-cycle period for compare tests.
`timescale 1ns/1ps
`include "capcom_defs.svh"
module test_capture_compare_unit;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic             ext_count_i, peer_ovf_i;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata;
    logic [`CH_N-1:0] pin_i, pin_o, pin_oe, ext_lvl;
    int               fail_count, n_tests, cycles;
    logic [6:0]       cfg_tab [8] = '{7'h05, 7'h04, 7'h07, 7'h47, 7'h06, 7'h00, 7'h05, 7'h05};
    logic [15:0]      val_tab [8] = '{16'hFFD0, 16'hFFE0, 16'hFFF0, 16'hFFF0, 16'hFFF8, 16'h0000, 16'hFFD0, 16'hFFE0};

    capture_compare_unit capture_compare_unit_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .ext_count_i(ext_count_i),
        .peer_ovf_i(peer_ovf_i), .irq(irq));
    pin_partner pin_partner_inst (.ext_lvl(ext_lvl), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        check(q, exp);
        check({31'h0, e}, {31'h0, err});
    endtask
    // Waits for a level, then records whether it arrived in time
    task automatic wait_pin(input int ch, input logic lvl, input int max);
        for (int i = 0; i < max && pin_o[ch] !== lvl; i++) @(posedge pclk);
        check({31'h0, pin_o[ch]}, {31'h0, lvl});
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial pclk = 1'b0;
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        ext_count_i = 1'b0; peer_ovf_i = 1'b0; ext_lvl = 16'h0000;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`OFS_CTRL, 32'h0, 1'b0);
        rd(`OFS_STS, 32'h0, 1'b0);
        rd(8'hC0, 32'h0, 1'b1);
        wr(8'h20, 32'h1);
        // ----------------------------------------
        // Compare modes on timer A, period 64
        // ----------------------------------------
        wr(`OFS_RELA, 32'hFFC0);
        wr(`OFS_TMRA, 32'hFFC0);
        for (int i = 0; i < 8; i++) begin
            wr(8'h40 + 8'(i * 4), {25'h0, cfg_tab[i]});
            wr(8'h80 + 8'(i * 4), {16'h0, val_tab[i]});
        end
        wr(`OFS_DBL, 32'h8);
        wr(`OFS_CTRL, 32'h1);
        // Single-event channel only pulses in the first period
        wait_pin(3, 1'b1, 140);
        wait_pin(3, 1'b0, 20);
        wait_pin(0, 1'b1, 140);
        wait_pin(0, 1'b0, 140);
        wait_pin(2, 1'b1, 140);
        wait_pin(2, 1'b0, 20);
        wait_pin(6, 1'b1, 140);
        wait_pin(6, 1'b0, 20);
        repeat (140) @(posedge pclk);
        check({31'h0, pin_o[3]}, 32'h0);
        check({30'h0, pin_oe[7], pin_oe[1]}, 32'h0);
        wr(`OFS_CTRL, 32'h0);
        rd(`OFS_STS, 32'h00DF, 1'b0);
        wr(`OFS_MSK, 32'h0002);
        check({31'h0, irq}, 32'h1);
        wr(`OFS_STS, 32'h0002);
        check({31'h0, irq}, 32'h0);
        wr(`OFS_MSK, 32'h0);
        wr(`OFS_STS, 32'hFFFF);
        // ----------------------------------------
        // Capture on timer B: rising, falling, both
        // ----------------------------------------
        wr(`OFS_TMRB, 32'h0ABC);
        wr(8'h60, 32'h29);
        wr(8'h64, 32'h31);
        wr(8'h68, 32'h39);
        ext_lvl[10:8] <= 3'b111;
        repeat (6) @(posedge pclk);
        rd(8'hA0, 32'h0ABC, 1'b0);
        rd(8'hA4, 32'h0, 1'b0);
        rd(`OFS_STS, 32'h0500, 1'b0);
        wr(`OFS_TMRB, 32'h0DEF);
        ext_lvl[10:8] <= 3'b000;
        repeat (6) @(posedge pclk);
        rd(8'hA0, 32'h0ABC, 1'b0);
        rd(8'hA4, 32'h0DEF, 1'b0);
        rd(8'hA8, 32'h0DEF, 1'b0);
        // External count on A, peer overflow pulses on B
        wr(`OFS_TMRA, 32'h0);
        wr(`OFS_TMRB, 32'h0);
        wr(`OFS_CTRL, 32'h0563);
        repeat (5) begin
            ext_count_i <= 1'b1;
            repeat (4) @(posedge pclk);
            ext_count_i <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        repeat (3) begin
            peer_ovf_i <= 1'b1;
            @(posedge pclk);
            peer_ovf_i <= 1'b0;
            repeat (2) @(posedge pclk);
        end
        repeat (6) @(posedge pclk);
        wr(`OFS_CTRL, 32'h0);
        rd(`OFS_TMRA, 32'h5, 1'b0);
        rd(`OFS_TMRB, 32'h3, 1'b0);
        // Run windows of 64 cycles: 61 idle edges, one of the start write, two of the stop write
        wr(`OFS_TMRA, 32'h0);
        wr(`OFS_CTRL, 32'h5);
        repeat (61) @(posedge pclk);
        wr(`OFS_CTRL, 32'h0);
        rd(`OFS_TMRA, 32'h8, 1'b0);
        wr(`OFS_TMRA, 32'h0);
        wr(`OFS_CTRL, 32'h41);
        repeat (61) @(posedge pclk);
        wr(`OFS_CTRL, 32'h0);
        rd(`OFS_TMRA, 32'h4, 1'b0);
        end_of_test();
    end
endmodule // test_capture_compare_unit

bind capture_compare_unit capcom_chk capcom_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .ext_count_i(ext_count_i),
    .peer_ovf_i(peer_ovf_i), .irq(irq));
